// File: rtl/stw_crc8.sv
// Serial CRC engine for the scratchpad stream
`timescale 1ns/1ps
`default_nettype none

module stw_crc8 (
  input  wire logic       hclk,    // Core clock
  input  wire logic       hresetn, // Async reset, active low
  input  wire logic       clear,   // Restart at zero
  input  wire logic       shift,   // Take one bit
  input  wire logic       din,     // Bit taken, LSB first
  output logic [7:0]      crc      // Running remainder
);
  import stw_pkg::*;

  // ==========================================================================
  // Shift register, cleared before every stream
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      crc <= 8'h00;
    else if (clear)
      crc <= 8'h00;
    else if (shift)
      crc <= stw_crc_step(crc, din);
  end

endmodule // stw_crc8

`default_nettype wire

// File: rtl/stw_pkg.sv
// Package: constants, carriers and helpers of the single-wire thermometer slave
package stw_pkg;

  // ==========================================================================
  // Clock and timing
  localparam int unsigned STW_CLK_HZ   = 125_000_000; // Core clock rate
  localparam int unsigned STW_TCONV_MS = 750;         // Full 12-bit conversion, ms
  localparam int unsigned STW_CONV_CYC = STW_TCONV_MS * (STW_CLK_HZ / 1000);

  // ==========================================================================
  // Link command codes
  localparam logic [7:0] STW_CMD_READ_ID = 8'h33; // Read identity
  localparam logic [7:0] STW_CMD_MATCH   = 8'h55; // Match identity
  localparam logic [7:0] STW_CMD_SKIP    = 8'hCC; // Skip identity
  localparam logic [7:0] STW_CMD_CONVERT = 8'h44; // Start conversion
  localparam logic [7:0] STW_CMD_RD_SP   = 8'hBE; // Read scratchpad
  localparam logic [7:0] STW_CMD_WR_SP   = 8'h4E; // Write scratchpad
  localparam logic [7:0] STW_CMD_COPY    = 8'h48; // Copy scratchpad to storage

  // ==========================================================================
  // Reset values and fixed patterns
  localparam logic [15:0] STW_TEMP_RST   = 16'h0550;      // +85 degrees
  localparam logic [1:0]  STW_RES_RST    = 2'h3;          // 12-bit resolution
  localparam logic [7:0]  STW_HAT_RST    = 8'h00;         // Stored high trigger
  localparam logic [7:0]  STW_LAT_RST    = 8'h00;         // Stored low trigger
  localparam logic [47:0] STW_SERIAL_RST = 48'h0000_0000_0001;
  localparam logic [7:0]  STW_SP_RSVD    = 8'hFF;         // Bytes 5 to 7
  localparam logic [4:0]  STW_CFG_ONES   = 5'h1F;         // Config bits 4:0
  localparam int unsigned STW_CFG_RES_LSB = 5;            // res_select_low
  localparam logic [7:0]  STW_CRC_POLY   = 8'h8C;         // Reflected x8+x5+x4+1

  // ==========================================================================
  // Register map (byte offsets)
  localparam logic [7:0] STW_OFS_SERIAL_LO = 8'h00;
  localparam logic [7:0] STW_OFS_SERIAL_HI = 8'h04;
  localparam logic [7:0] STW_OFS_SENSOR    = 8'h08;
  localparam logic [7:0] STW_OFS_STATUS    = 8'h0C;
  localparam logic [7:0] STW_OFS_TEMP      = 8'h10;
  localparam logic [7:0] STW_OFS_TRIG      = 8'h14;

  // Status register bit positions
  localparam int unsigned STW_ST_ALARM  = 0;
  localparam int unsigned STW_ST_BUSY   = 1;
  localparam int unsigned STW_ST_ACCESS = 2;
  localparam int unsigned STW_ST_RES    = 3; // Two bits
  localparam int unsigned STW_ST_SUPPLY = 5;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic bus_reset; // Reset pulse seen on the wire
    logic wr_slot;   // Write slot decoded
    logic wr_bit;    // Bit of that write slot
    logic rd_slot;   // Read slot sampled now
  } stw_slot_t;

  typedef struct packed {
    logic presence;  // Presence answer
    logic rd_bit;    // Bit offered to the next read slot
  } stw_answer_t;

  // ==========================================================================
  // CRC helpers
  function automatic logic [7:0] stw_crc_step(input logic [7:0] crc, input logic b);
    logic [7:0] nxt;
    nxt = {1'b0, crc[7:1]};
    if (crc[0] ^ b)
      nxt = nxt ^ STW_CRC_POLY;
    return nxt;
  endfunction

  function automatic logic [7:0] stw_crc56(input logic [55:0] d);
    logic [7:0] crc;
    crc = 8'h00;
    for (int i = 0; i < 56; i++)
      crc = stw_crc_step(crc, d[i]);
    return crc;
  endfunction

endpackage

// File: rtl/stw_thermo_slave.sv
// Single-wire thermometer slave: command engine, scratchpad, conversion, AHB-Lite
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - function commands only after identity addressing
// - one function command per addressed access
// - start-conversion fills scratchpad bytes zero, one
// - temperature is 16-bit sign-extended two's complement
// - 9 to 12 bit resolution, default 12
// - unused low bits forced to zero
// - scratchpad-read returns the scratchpad contents
// - every byte moves LSB first
// - temperature resets to +85 degrees code
// - 12-bit code is degrees times sixteen
// - alarm compares integer part with 8-bit triggers
// - alarm flag updated after every conversion
// - alarm search answered only while alarming
// - triggers are stored bytes, usable as user
// - identity is family, serial, then CRC
// - CRC polynomial x8 + x5 + x4 + 1
// - supply query answers 0 parasite, 1 local
// - locally supplied devices convert together, traffic continues
// - CRC starts at zero, stored CRC gives zero
// - scratchpad byte layout, CRC in byte eight
// - resolution bits select time, halving per bit
// - read-identity sends family, serial and CRC
module stw_thermo_slave #(
  parameter logic [7:0]  FAMILY_CODE      = 8'h5A, // Arbitrary value
  parameter int unsigned CONV_CYCLES      = stw_pkg::STW_CONV_CYC,
  parameter logic [7:0]  CMD_SEARCH       = 8'hF0,
  parameter logic [7:0]  CMD_ALARM_SEARCH = 8'hEC,
  parameter logic [7:0]  CMD_READ_SUPPLY  = 8'hB4,
  parameter logic [7:0]  CMD_RECALL       = 8'hB8
) (
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic                       hresp,
  output logic [31:0]                hrdata,
  input  wire stw_pkg::stw_slot_t    slot_in,
  output var  stw_pkg::stw_answer_t  answer,
  input  wire logic                  local_supply_pin
);
  import stw_pkg::*;

  // ==========================================================================
  // Command engine states
  typedef enum logic [9:0] {
    S_IDLE   = 10'b0000000001, // Deaf until next bus reset
    S_ROMCMD = 10'b0000000010, // Collect identity command
    S_ROMTX  = 10'b0000000100, // Send identity
    S_MATCH  = 10'b0000001000, // Compare identity
    S_SEARCH = 10'b0000010000, // Search triplets
    S_FUNCMD = 10'b0000100000, // Collect function command
    S_SPTX   = 10'b0001000000, // Send scratchpad
    S_SPRX   = 10'b0010000000, // Take trigger and config bytes
    S_STATTX = 10'b0100000000, // Answer status read slots
    S_DONE   = 10'b1000000000  // Command over, slots read as 1
  } stw_state_t;

  stw_state_t  state_q;      // Engine state
  logic [6:0]  cnt_q;        // Bit counter within a stream
  logic [1:0]  phase_q;      // Search triplet phase
  logic [7:0]  rx_q;         // Command shift register
  logic        miss_q;       // Identity mismatch seen
  logic        stat_conv_q;  // Status slots show conversion
  logic [15:0] temp_q;       // Temperature register
  logic        alarm_q;      // Alarm flag
  logic [7:0]  sp_hat_q;     // Scratch high_alarm_trigger
  logic [7:0]  sp_lat_q;     // Scratch low_alarm_trigger
  logic [1:0]  sp_res_q;     // {res_select_high, res_select_low}
  logic [7:0]  nv_hat_q;     // Stored high_alarm_trigger
  logic [7:0]  nv_lat_q;     // Stored low_alarm_trigger
  logic [1:0]  nv_res_q;     // Stored resolution
  logic        busy_q;       // Conversion running
  logic [31:0] conv_cnt_q;   // Conversion timer
  logic [47:0] serial_q;     // Serial number
  logic [15:0] sensor_q;     // Raw sensor reading
  logic        wr_pend_q;    // AHB write in data phase
  logic [7:0]  wr_addr_q;    // Its offset
  logic        presence_q;   // Presence answer
  logic        rd_bit_q;     // Bit for next read slot

  // ==========================================================================
  // Derived values
  logic [63:0] rom_word;     // Identity, bit 0 sent first
  logic        rom_bit;      // Identity bit at counter
  logic [7:0]  rx_next;      // Command byte with new bit
  logic        byte_done;    // Eighth bit of a byte written
  logic        fun_go;       // Function command complete
  logic        conv_start;   // Start-conversion accepted
  logic        copy_go;      // Copy to storage
  logic        recall_go;    // Recall from storage
  logic [7:0]  cfg_byte;     // Config as read back
  logic [7:0]  sp_byte;      // Scratchpad byte at counter
  logic        tx_bit;       // Bit to offer next
  logic [7:0]  crc;          // Scratchpad CRC
  logic [31:0] conv_target;  // Cycles for this resolution
  logic [15:0] temp_new;     // Masked result
  logic signed [11:0] t_int; // Integer degrees
  logic signed [11:0] t_hi;  // High trigger, sign extended
  logic signed [11:0] t_lo;  // Low trigger, sign extended
  logic        ap_valid;     // AHB address phase taken
  logic [31:0] rd_mux;       // AHB read value

  assign rom_word = {stw_crc56({serial_q, FAMILY_CODE}), serial_q, FAMILY_CODE};
  assign rom_bit  = rom_word[cnt_q[5:0]];
  assign rx_next  = {slot_in.wr_bit, rx_q[7:1]};
  assign byte_done = slot_in.wr_slot && (cnt_q[2:0] == 3'h7);
  assign fun_go     = (state_q == S_FUNCMD) && byte_done;
  assign conv_start = fun_go && (rx_next == STW_CMD_CONVERT);
  assign copy_go    = fun_go && (rx_next == STW_CMD_COPY);
  assign recall_go  = fun_go && (rx_next == CMD_RECALL);
  assign cfg_byte   = {1'b0, sp_res_q, STW_CFG_ONES};

  // ==========================================================================
  // Scratchpad byte selection
  always_comb
  begin
    unique case (cnt_q[5:3])
      3'h0:    sp_byte = temp_q[7:0];
      3'h1:    sp_byte = temp_q[15:8];
      3'h2:    sp_byte = sp_hat_q;
      3'h3:    sp_byte = sp_lat_q;
      3'h4:    sp_byte = cfg_byte;
      default: sp_byte = STW_SP_RSVD;
    endcase
  end

  // ==========================================================================
  // Bit offered to the next read slot; idle wire reads as 1
  always_comb
  begin
    tx_bit = 1'b1;
    unique case (state_q)
      S_ROMTX:  tx_bit = rom_bit;
      S_SEARCH: tx_bit = (phase_q == 2'h0) ? rom_bit : !rom_bit;
      S_SPTX:   tx_bit = cnt_q[6] ? crc[cnt_q[2:0]] : sp_byte[cnt_q[2:0]];
      S_STATTX: tx_bit = stat_conv_q ? !busy_q : local_supply_pin;
      default:  tx_bit = 1'b1;
    endcase
  end

  // ==========================================================================
  // Scratchpad CRC: cleared at the read command, fed with the 64 sent data bits
  stw_crc8 u_crc (
    .hclk    (hclk),
    .hresetn (hresetn),
    .clear   (fun_go && (rx_next == STW_CMD_RD_SP)),
    .shift   ((state_q == S_SPTX) && slot_in.rd_slot && !cnt_q[6]),
    .din     (tx_bit),
    .crc     (crc)
  );

  // ==========================================================================
  // Command engine
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_q     <= S_IDLE;
      cnt_q       <= 7'h00;
      phase_q     <= 2'h0;
      rx_q        <= 8'h00;
      miss_q      <= 1'b0;
      stat_conv_q <= 1'b0;
    end
    else if (slot_in.bus_reset)
    begin
      // Any reset pulse drops the current command
      state_q <= S_ROMCMD;
      cnt_q   <= 7'h00;
      phase_q <= 2'h0;
      miss_q  <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        S_IDLE, S_DONE, S_STATTX:
        begin
          // Wait for the next bus reset
        end
        S_ROMCMD:
        begin
          if (slot_in.wr_slot)
          begin
            rx_q  <= rx_next;
            cnt_q <= byte_done ? 7'h00 : cnt_q + 7'h01;
          end
          if (byte_done)
          begin
            if (rx_next == STW_CMD_READ_ID)
              state_q <= S_ROMTX;
            else if (rx_next == STW_CMD_MATCH)
              state_q <= S_MATCH;
            else if (rx_next == CMD_SEARCH)
              state_q <= S_SEARCH;
            else if (rx_next == STW_CMD_SKIP)
              state_q <= S_FUNCMD;
            else if (rx_next == CMD_ALARM_SEARCH)
              state_q <= alarm_q ? S_SEARCH : S_IDLE;
            else
              state_q <= S_IDLE;
          end
        end
        S_ROMTX:
        begin
          if (slot_in.rd_slot)
          begin
            cnt_q <= (cnt_q == 7'd63) ? 7'h00 : cnt_q + 7'h01;
            if (cnt_q == 7'd63)
              state_q <= S_FUNCMD;
          end
        end
        S_MATCH:
        begin
          if (slot_in.wr_slot)
          begin
            cnt_q  <= (cnt_q == 7'd63) ? 7'h00 : cnt_q + 7'h01;
            miss_q <= miss_q || (slot_in.wr_bit != rom_bit);
            if (cnt_q == 7'd63)
              state_q <= (miss_q || (slot_in.wr_bit != rom_bit)) ? S_IDLE : S_FUNCMD;
          end
        end
        S_SEARCH:
        begin
          // Bit, complement, then the master's chosen direction
          if (slot_in.rd_slot && (phase_q != 2'h2))
            phase_q <= phase_q + 2'h1;
          else if (slot_in.wr_slot && (phase_q == 2'h2))
          begin
            phase_q <= 2'h0;
            cnt_q   <= (cnt_q == 7'd63) ? 7'h00 : cnt_q + 7'h01;
            if (slot_in.wr_bit != rom_bit)
              state_q <= S_IDLE;
            else if (cnt_q == 7'd63)
              state_q <= S_FUNCMD;
          end
        end
        S_FUNCMD:
        begin
          if (slot_in.wr_slot)
          begin
            rx_q  <= rx_next;
            cnt_q <= byte_done ? 7'h00 : cnt_q + 7'h01;
          end
          if (byte_done)
          begin
            if (rx_next == STW_CMD_CONVERT)
            begin
              state_q     <= S_STATTX;
              stat_conv_q <= 1'b1;
            end
            else if (rx_next == CMD_READ_SUPPLY)
            begin
              state_q     <= S_STATTX;
              stat_conv_q <= 1'b0;
            end
            else if (rx_next == STW_CMD_RD_SP)
              state_q <= S_SPTX;
            else if (rx_next == STW_CMD_WR_SP)
              state_q <= S_SPRX;
            else if ((rx_next == STW_CMD_COPY) || (rx_next == CMD_RECALL))
              state_q <= S_DONE;
            else
              state_q <= S_IDLE;
          end
        end
        S_SPTX:
        begin
          if (slot_in.rd_slot)
          begin
            cnt_q <= cnt_q + 7'h01;
            if (cnt_q == 7'd71)
              state_q <= S_DONE;
          end
        end
        S_SPRX:
        begin
          if (slot_in.wr_slot)
          begin
            rx_q  <= rx_next;
            cnt_q <= cnt_q + 7'h01;
            if (cnt_q == 7'd23)
              state_q <= S_DONE;
          end
        end
        default:
          state_q <= S_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Scratchpad trigger and config bytes
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sp_hat_q <= STW_HAT_RST;
      sp_lat_q <= STW_LAT_RST;
      sp_res_q <= STW_RES_RST;
    end
    else if (recall_go)
    begin
      sp_hat_q <= nv_hat_q;
      sp_lat_q <= nv_lat_q;
      sp_res_q <= nv_res_q;
    end
    else if ((state_q == S_SPRX) && byte_done && !slot_in.bus_reset)
    begin
      // Config bits other than resolution are fixed on read-back
      unique case (cnt_q[4:3])
        2'h0:    sp_hat_q <= rx_next;
        2'h1:    sp_lat_q <= rx_next;
        default: sp_res_q <= rx_next[STW_CFG_RES_LSB +: 2];
      endcase
    end
  end

  // ==========================================================================
  // Stored triggers and config, loaded by copy
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      nv_hat_q <= STW_HAT_RST;
      nv_lat_q <= STW_LAT_RST;
      nv_res_q <= STW_RES_RST;
    end
    else if (copy_go)
    begin
      nv_hat_q <= sp_hat_q;
      nv_lat_q <= sp_lat_q;
      nv_res_q <= sp_res_q;
    end
  end

  // ==========================================================================
  // Conversion: time halves per resolution bit removed
  assign conv_target = CONV_CYCLES >> ~sp_res_q;
  assign temp_new    = sensor_q & (16'hFFFF << ~sp_res_q);
  assign t_int       = temp_new[15:4];
  assign t_hi        = {{4{sp_hat_q[7]}}, sp_hat_q};
  assign t_lo        = {{4{sp_lat_q[7]}}, sp_lat_q};

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      busy_q     <= 1'b0;
      conv_cnt_q <= 32'h0000_0000;
      temp_q     <= STW_TEMP_RST;
      alarm_q    <= 1'b0;
    end
    else if (conv_start && !busy_q)
    begin
      busy_q     <= 1'b1;
      conv_cnt_q <= 32'h0000_0000;
    end
    else if (busy_q)
    begin
      if (conv_cnt_q + 32'h1 >= conv_target)
      begin
        busy_q  <= 1'b0;
        temp_q  <= temp_new;
        alarm_q <= (t_int > t_hi) || (t_int < t_lo);
      end
      else
        conv_cnt_q <= conv_cnt_q + 32'h1;
    end
  end

  // ==========================================================================
  // Link answers, registered
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      presence_q <= 1'b0;
      rd_bit_q   <= 1'b1;
    end
    else
    begin
      presence_q <= slot_in.bus_reset;
      rd_bit_q   <= tx_bit;
    end
  end

  assign answer = '{presence: presence_q, rd_bit: rd_bit_q};

  // ==========================================================================
  // AHB-Lite slave, zero wait states, always OKAY
  assign ap_valid  = hsel && hready && htrans[1];
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // Read value of the addressed word; unmapped reads as zero
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (haddr[31:8] == 24'h00_0000)
    begin
      unique case (haddr[7:0])
        STW_OFS_SERIAL_LO: rd_mux = serial_q[31:0];
        STW_OFS_SERIAL_HI: rd_mux = {16'h0000, serial_q[47:32]};
        STW_OFS_SENSOR:    rd_mux = {16'h0000, sensor_q};
        STW_OFS_STATUS:
        begin
          rd_mux[STW_ST_ALARM]       = alarm_q;
          rd_mux[STW_ST_BUSY]        = busy_q;
          rd_mux[STW_ST_ACCESS]      = (state_q == S_FUNCMD);
          rd_mux[STW_ST_RES +: 2]    = sp_res_q;
          rd_mux[STW_ST_SUPPLY]      = local_supply_pin;
        end
        STW_OFS_TEMP:      rd_mux = {16'h0000, temp_q};
        STW_OFS_TRIG:      rd_mux = {8'h00, cfg_byte, sp_lat_q, sp_hat_q};
        default:           rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // Address phase capture and registered read data
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      hrdata    <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_q <= ap_valid && hwrite && (haddr[31:8] == 24'h00_0000) && (hsize == 3'h2);
      wr_addr_q <= haddr[7:0];
      hrdata    <= (ap_valid && !hwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // Data phase writes; serial and sensor feed the link logic
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      serial_q <= STW_SERIAL_RST;
      sensor_q <= STW_TEMP_RST;
    end
    else if (wr_pend_q)
    begin
      if (wr_addr_q == STW_OFS_SERIAL_LO)
        serial_q[31:0] <= hwdata;
      else if (wr_addr_q == STW_OFS_SERIAL_HI)
        serial_q[47:32] <= hwdata[15:0];
      else if (wr_addr_q == STW_OFS_SENSOR)
        sensor_q <= hwdata[15:0];
    end
  end

endmodule // stw_thermo_slave

`default_nettype wire

// File: testbench/stw_master_model.sv
// Partner: bus master controller issuing link slots
`timescale 1ns/1ps
`default_nettype none
module stw_master_model (
  input  wire logic                 hclk,
  output stw_pkg::stw_slot_t        slot_in,
  input  wire stw_pkg::stw_answer_t answer
);
  import stw_pkg::*;
  logic seen, junk; // Presence sampled after the last pulse, unused sampled bit
  initial slot_in = '0;
  // One pulse, three quiet cycles so rd_bit settles before the next
  task automatic pulse(input stw_slot_t s, output logic b);
    @(posedge hclk);
    b = answer.rd_bit;
    slot_in <= s;
    @(posedge hclk);
    slot_in <= '0;
    @(posedge hclk);
    seen = answer.presence;
    @(posedge hclk);
  endtask
  task automatic rst;
    pulse(4'h8, junk);
  endtask
  // Bytes leave LSB first
  task automatic wb(input logic [7:0] d);
    for (int i = 0; i < 8; i++)
      pulse({2'h1, d[i], 1'b0}, junk);
  endtask
  // Read slots, first bit lands in q[0]
  task automatic rb(input int n, output logic [63:0] q);
    q = '0;
    for (int i = 0; i < n; i++)
      pulse(4'h1, q[i]);
  endtask
endmodule // stw_master_model
`default_nettype wire

// File: testbench/stw_monitor.sv
// Checker: port-level assertions for the thermometer slave
`timescale 1ns/1ps
`default_nettype none
module stw_monitor (
  input wire logic                 hclk,
  input wire logic                 hresetn,
  input wire logic                 hsel,
  input wire logic [31:0]          haddr,
  input wire logic [1:0]           htrans,
  input wire logic                 hwrite,
  input wire logic                 hready,
  input wire logic                 hreadyout,
  input wire logic                 hresp,
  input wire logic [31:0]          hrdata,
  input wire stw_pkg::stw_slot_t   slot_in,
  input wire stw_pkg::stw_answer_t answer,
  input wire logic                 local_supply_pin
);
  import stw_pkg::*;
  // ==========================================================================
  // Data-phase tracking of reads
  logic       rd_q; // Read now in data phase
  logic [7:0] a_q;  // Offset of that read
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      rd_q <= 1'b0;
      a_q  <= 8'h00;
    end
    else
    begin
      rd_q <= hsel && hready && htrans[1] && !hwrite;
      a_q  <= haddr[7:0];
    end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ==========================================================================
  // Assertions
  a_pres_follows: assert property (slot_in.bus_reset |=> answer.presence)
    else $error("no presence");
  a_pres_cause: assert property (answer.presence |-> $past(slot_in.bus_reset))
    else $error("stray presence");
  a_ready_high: assert property (hreadyout)
    else $error("wait state");
  a_resp_okay: assert property (!hresp)
    else $error("error response");
  a_idle_zero: assert property (!rd_q |-> hrdata == 32'h0)
    else $error("read data outside data phase");
  a_supply_bit: assert property (rd_q && a_q == STW_OFS_STATUS |-> hrdata[STW_ST_SUPPLY] == $past(local_supply_pin))
    else $error("supply bit wrong");
  a_temp_width: assert property (rd_q && a_q == STW_OFS_TEMP |-> hrdata[31:16] == 16'h0)
    else $error("temperature wider than 16 bits");
  a_cfg_fixed: assert property (rd_q && a_q == STW_OFS_TRIG |-> hrdata[20:16] == STW_CFG_ONES && !hrdata[23])
    else $error("config fixed bits wrong");
  // Main scenarios reached
  c_bus_reset: cover property (slot_in.bus_reset);
  c_temp_read: cover property (rd_q && a_q == STW_OFS_TEMP);
  c_zero_bit: cover property (slot_in.rd_slot && !answer.rd_bit);
endmodule // stw_monitor
bind stw_thermo_slave stw_monitor u_mon (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready,
  .hreadyout, .hresp, .hrdata, .slot_in, .answer, .local_supply_pin);
`default_nettype wire

// File: testbench/stw_thermo_slave_tb_top.sv
// Testbench: link and register scenarios for the thermometer slave
`timescale 1ns/1ps
`default_nettype none
module stw_thermo_slave_tb_top;
  import stw_pkg::*;
  localparam logic [7:0] FAM = 8'h3C; // Arbitrary family value
  localparam logic [7:0] TH  = 8'h19; // +25 degrees
  localparam logic [7:0] TL  = 8'hF0; // -16 degrees
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, local_supply_pin, al;
  logic [31:0] haddr, hwdata, hrdata, r, w;
  logic [1:0]  htrans, rs;
  logic [15:0] s, e;
  logic [63:0] v, q;
  stw_slot_t   slot_in;
  stw_answer_t answer;
  int          errors, num_checks;
  // Sensor code, resolution, expected result, expected alarm
  logic [34:0] rows [7] = '{{16'h07D0, 2'h3, 16'h07D0, 1'b1}, {16'hFC90, 2'h3, 16'hFC90, 1'b1},
    {16'h01A0, 2'h3, 16'h01A0, 1'b1}, {16'h019F, 2'h3, 16'h019F, 1'b0}, {16'hFF5E, 2'h0, 16'hFF58, 1'b0},
    {16'hFF5E, 2'h1, 16'hFF5C, 1'b0}, {16'hFF5E, 2'h2, 16'hFF5E, 1'b0}};
  stw_thermo_slave #(.FAMILY_CODE(FAM), .CONV_CYCLES(64)) dut (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .slot_in, .answer,
    .local_supply_pin);
  stw_master_model m (.hclk, .slot_in, .answer);
  initial
  begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  task automatic chk(input logic [63:0] g, input logic [63:0] x);
    num_checks++;
    if (g !== x)
      $display("CHECK FAILED t=%0t got %0h exp %0h", $time, g, x);
    errors += int'(g !== x);
  endtask
  // Single word transfer; data taken at the edge ending the data phase
  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d, output logic [31:0] o);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    do @(posedge hclk); while (!hreadyout);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (!hreadyout);
    o = hrdata;
  endtask
  // Reset pulse, skip identity, then one function command
  task automatic cmd(input logic [7:0] c);
    m.rst();
    m.wb(STW_CMD_SKIP);
    m.wb(c);
  endtask
  function automatic logic [7:0] crc(input logic [7:0] c, input logic [63:0] d, input int n);
    for (int i = 0; i < n; i++)
      c = {1'b0, c[7:1]} ^ ((c[0] ^ d[i]) ? STW_CRC_POLY : 8'h00);
    return c;
  endfunction
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Watchdog well past the expected run of some 27 us
  initial
  begin
    #200_000;
    errors++;
    summarize();
  end
  initial
  begin
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    local_supply_pin = 1'b1;
    hresetn = 1'b0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    bus(STW_OFS_TEMP, 0, 0, r);
    chk(r, 32'h0550);
    bus(STW_OFS_TRIG, 0, 0, r);
    chk(r, 32'h007F0000);
    bus(8'h40, 0, 0, r);
    chk(r, 0);
    $display("test reset values done");
    m.rst();
    m.wb(STW_CMD_CONVERT);
    bus(STW_OFS_STATUS, 0, 0, r);
    chk(r[STW_ST_BUSY], 0);
    m.rst();
    m.wb(STW_CMD_SKIP);
    bus(STW_OFS_STATUS, 0, 0, r);
    chk(r[STW_ST_ACCESS], 1);
    m.rst();
    bus(STW_OFS_STATUS, 0, 0, r);
    chk(r[STW_ST_ACCESS], 0);
    for (int p = 0; p < 2; p++)
    begin
      local_supply_pin <= p[0];
      cmd(8'hB4);
      m.rb(1, v);
      chk(v[0], p[0]);
    end
    $display("test gating and supply done");
    m.rst();
    chk(m.seen, 1);
    m.wb(STW_CMD_READ_ID);
    m.rb(64, v);
    chk(v[55:0], {STW_SERIAL_RST, FAM});
    chk(crc(8'h00, v, 56), v[63:56]);
    chk(crc(8'h00, v, 64), 0);
    $display("test identity done");
    foreach (rows[k])
    begin
      {s, rs, e, al} = rows[k];
      bus(STW_OFS_SENSOR, 1, {16'h0, s}, r);
      cmd(STW_CMD_WR_SP);
      m.wb(TH);
      m.wb(TL);
      m.wb({1'b0, rs, 5'h1F});
      if (k == 0)
        cmd(STW_CMD_COPY);
      cmd(STW_CMD_CONVERT);
      do bus(STW_OFS_STATUS, 0, 0, r); while (r[STW_ST_BUSY] !== 1'b0);
      bus(STW_OFS_TEMP, 0, 0, w);
      bus(STW_OFS_STATUS, 0, 0, r);
      chk(w, {16'h0, e});
      chk(r[STW_ST_ALARM], al);
      m.rst();
      m.wb(8'hEC);
      m.rb(2, v);
      chk(v[1:0], al ? {~FAM[0], FAM[0]} : 2'h3);
      $display("test conversion %0d done", k);
    end
    cmd(STW_CMD_RD_SP);
    m.rb(64, v);
    m.rb(8, q);
    chk(v[39:0], {8'h5F, TL, TH, 16'hFF5E});
    chk(crc(crc(8'h00, v, 64), q, 8), 0);
    cmd(8'hB8);
    bus(STW_OFS_TRIG, 0, 0, r);
    chk(r, {8'h00, 8'h7F, TL, TH});
    $display("test scratchpad done");
    summarize();
  end
endmodule // stw_thermo_slave_tb_top
`default_nettype wire
